/* File: verilog/rswc_ctrl.v */
// Reset, sleep and wake-up controller of a small 8-bit microcontroller.
// Assumes an APB master for software access and core event strobes that
// are synchronous to clk; timers, comparator and ADC lie outside.
`timescale 1ns/1ps
`include "rswc_map.vh"

module rswc_ctrl #(
   parameter HOLD_CYC = `RSWC_HOLD_CYC,
   parameter SLOW_HOLD_CYC = `RSWC_SLOW_HOLD_CYC,
   parameter WDT_LONG_CYC = `RSWC_WDT_LONG_CYC,
   parameter WDT_SHORT_CYC = `RSWC_WDT_SHORT_CYC,
   parameter XTAL_START_CYC = `RSWC_XTAL_START_CYC
) (
   // Clock and power-on reset.
   input wire clk,
   input wire reset,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // External pins.
   input wire reset_pin_n,
   input wire [7:0] port_five_pins,
   // Core events.
   input wire sleep_instr,
   input wire clear_watchdog_instr,
   input wire port_five_read,
   input wire global_irq_on,
   input wire comparator_change,
   input wire adc_busy,
   input wire adc_done,
   input wire adc_clock_tick,
   input wire [1:0] osc_mode,
   // Core control.
   output wire core_reset,
   output wire osc_run,
   output wire timers_run,
   output wire adc_stop,
   output wire pc_load,
   output wire [9:0] pc_word,
   output wire port_inputs_only,
   output wire watchdog_timeout
);

   localparam ST_RESET = 4'b0001;
   localparam ST_RUN = 4'b0010;
   localparam ST_SLEEP = 4'b0100;
   localparam ST_WAKE = 4'b1000;

   reg [3:0] state_reg;
   reg [24:0] hold_cnt_reg;
   reg [24:0] wdt_cnt_reg;
   reg [7:0] wdt_pre_reg;
   reg [7:0] watchdog_ctrl_reg;
   reg [7:0] wake_enables;
   reg [7:0] irq_mask_reg;
   reg [7:0] irq_flags;
   reg [7:0] status_byte;
   reg [7:0] pin_option_reg_one;
   reg [7:0] pin_option_reg_two;
   reg [7:0] pin_option_reg_three;
   reg [7:0] port_five_data;
   reg [9:0] pc_reg;
   reg pc_load_reg;
   reg keep_run_reg;
   reg vec_en_reg;
   reg por_reg;
   reg timeout_cause_reg;
   reg adc_wake_reg;
   reg [9:0] wake_vec_reg;
   reg port_change_q_reg;

   wire wdt_on = watchdog_ctrl_reg[`RSWC_WDT_EN_BIT];
   wire [24:0] wdt_limit = watchdog_ctrl_reg[`RSWC_WDT_SHORT_BIT] ?
      WDT_SHORT_CYC[24:0] : WDT_LONG_CYC[24:0];
   wire wdt_expire = wdt_on && (wdt_cnt_reg >= wdt_limit - 25'h1);
   wire pin_low = !reset_pin_n;
   wire port_change = |(port_five_pins ^ port_five_data);
   wire port_wake = port_change &&
      wake_enables[`RSWC_WAKE_PORT_BIT];
   wire cmp_wake = comparator_change && wake_enables[`RSWC_WAKE_CMP_BIT];
   wire adc_wake = adc_done && wake_enables[`RSWC_WAKE_ADC_BIT];
   wire wr = psel && penable && pwrite;
   wire [24:0] reset_hold = (osc_mode == `RSWC_OSC_SLOW) ?
      SLOW_HOLD_CYC[24:0] : HOLD_CYC[24:0];
   wire [24:0] osc_wait = (osc_mode == `RSWC_OSC_SLOW) ?
      SLOW_HOLD_CYC[24:0] : (osc_mode == `RSWC_OSC_HXT) ?
      XTAL_START_CYC[24:0] + 25'd32 : 25'd32;
   wire reset_event = pin_low || wdt_expire;
   wire in_sleep = state_reg == ST_SLEEP;

   // APB answers in the access cycle with no wait states.
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // Oscillator stops in sleep unless an ADC wake keeps it going.
   assign core_reset = state_reg == ST_RESET;
   assign osc_run = !in_sleep || keep_run_reg;
   assign timers_run = (state_reg == ST_RUN) || keep_run_reg;
   assign adc_stop = in_sleep && !keep_run_reg;
   assign pc_load = pc_load_reg;
   assign pc_word = pc_reg;
   assign port_inputs_only = core_reset;
   assign watchdog_timeout = wdt_expire;

   // Read mux; unmapped addresses read as zero.
   always @* begin
      prdata = 32'h0;
      if (paddr == `RSWC_ADDR_WDT) begin
         prdata[7:0] = watchdog_ctrl_reg;
      end else if (paddr == `RSWC_ADDR_WAKE) begin
         prdata[7:0] = wake_enables;
      end else if (paddr == `RSWC_ADDR_MASK) begin
         prdata[7:0] = irq_mask_reg;
      end else if (paddr == `RSWC_ADDR_FLAGS) begin
         prdata[7:0] = irq_flags;
      end else if (paddr == `RSWC_ADDR_STATUS) begin
         prdata[7:0] = status_byte;
      end else if (paddr == `RSWC_ADDR_OPT1) begin
         prdata[7:0] = pin_option_reg_one;
      end else if (paddr == `RSWC_ADDR_OPT2) begin
         prdata[7:0] = pin_option_reg_two;
      end else if (paddr == `RSWC_ADDR_OPT3) begin
         prdata[7:0] = pin_option_reg_three;
      end else if (paddr == `RSWC_ADDR_STATE) begin
         prdata[3:0] = state_reg;
      end else if (paddr == `RSWC_ADDR_PORT5) begin
         prdata[7:0] = port_five_data;
      end
   end

   // Watchdog counter; it runs on its own in sleep as well.
   always @(posedge clk) begin
      if (reset || core_reset || clear_watchdog_instr || sleep_instr ||
          wdt_expire) begin
         wdt_cnt_reg <= 25'h0;
         wdt_pre_reg <= 8'h00;
      end else if (wdt_on) begin
         wdt_cnt_reg <= wdt_cnt_reg + 25'h1;
         wdt_pre_reg <= wdt_pre_reg + 8'h01;
      end
   end

   // Port 5 latch follows the pins whenever software reads the port.
   always @(posedge clk) begin
      if (reset) begin
         port_five_data <= 8'h00;
      end else if (port_five_read) begin
         port_five_data <= port_five_pins;
      end
   end

   // Last cycle's change level, so that a standing difference branches once.
   always @(posedge clk) begin
      if (reset) begin
         port_change_q_reg <= 1'b0;
      end else begin
         port_change_q_reg <= port_change;
      end
   end

   // Sequencer: reset hold, run, sleep and the wake wait.
   always @(posedge clk) begin
      pc_load_reg <= 1'b0;
      if (reset) begin
         state_reg <= ST_RESET;
         hold_cnt_reg <= 25'h0;
         pc_reg <= `RSWC_VEC_RESET;
         keep_run_reg <= 1'b0;
         vec_en_reg <= 1'b0;
         adc_wake_reg <= 1'b0;
         wake_vec_reg <= `RSWC_VEC_RESET;
      end else if (reset_event) begin
         state_reg <= ST_RESET;
         hold_cnt_reg <= 25'h0;
         keep_run_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_RESET: begin
               if (hold_cnt_reg >= reset_hold - 25'h1) begin
                  state_reg <= ST_RUN;
                  pc_reg <= `RSWC_VEC_RESET;
                  pc_load_reg <= 1'b1;
               end else begin
                  hold_cnt_reg <= hold_cnt_reg + 25'h1;
               end
            end
            ST_RUN: begin
               if (sleep_instr) begin
                  state_reg <= ST_SLEEP;
                  vec_en_reg <= global_irq_on;
                  keep_run_reg <= adc_busy &&
                     wake_enables[`RSWC_WAKE_ADC_BIT];
               end else if (port_change && !port_change_q_reg &&
                  irq_mask_reg[`RSWC_MASK_PORT_BIT] && global_irq_on) begin
                  pc_reg <= `RSWC_VEC_PORT;
                  pc_load_reg <= 1'b1;
               end
            end
            ST_SLEEP: begin
               hold_cnt_reg <= 25'h0;
               if (port_wake || cmp_wake || adc_wake) begin
                  state_reg <= ST_WAKE;
                  adc_wake_reg <= adc_wake;
                  wake_vec_reg <= port_wake ? `RSWC_VEC_PORT :
                     cmp_wake ? `RSWC_VEC_CMP : `RSWC_VEC_ADC;
               end
            end
            ST_WAKE: begin
               if (adc_wake_reg ? (hold_cnt_reg >= 25'd15) :
                   (hold_cnt_reg >= osc_wait)) begin
                  state_reg <= ST_RUN;
                  keep_run_reg <= 1'b0;
                  if (vec_en_reg) begin
                     pc_reg <= wake_vec_reg;
                     pc_load_reg <= 1'b1;
                  end // otherwise the core simply continues.
               end else if (!adc_wake_reg || adc_clock_tick) begin
                  hold_cnt_reg <= hold_cnt_reg + 25'h1;
               end
            end
            default: begin
               state_reg <= ST_RESET;
            end
         endcase
      end
   end

   // Cause flags for the status byte, captured at each reset event.
   always @(posedge clk) begin
      if (reset) begin
         por_reg <= 1'b1;
         timeout_cause_reg <= 1'b0;
      end else if (reset_event) begin
         por_reg <= 1'b0;
         timeout_cause_reg <= wdt_expire;
      end else if (state_reg == ST_RUN) begin
         por_reg <= 1'b0;
      end
   end

   // Software registers with their reset-time values.
   always @(posedge clk) begin
      if (reset) begin
         status_byte <= 8'h18;
         watchdog_ctrl_reg <= 8'h00;
         wake_enables <= 8'h00;
      end else if (core_reset) begin
         if (por_reg) begin
            status_byte <= (status_byte & `RSWC_STAT_POR_MASK);
         end
         status_byte[`RSWC_STAT_TO_BIT] <= !timeout_cause_reg;
         status_byte[`RSWC_STAT_PD_BIT] <= !(timeout_cause_reg && 1'b1);
         watchdog_ctrl_reg <= watchdog_ctrl_reg & `RSWC_WDT_CLR_MASK;
         wake_enables <= wake_enables & `RSWC_WAKE_CLR_MASK;
      end else begin
         if (sleep_instr && state_reg == ST_RUN) begin
            status_byte[`RSWC_STAT_PD_BIT] <= 1'b0;
         end else if (wr && paddr == `RSWC_ADDR_STATUS) begin
            status_byte <= pwdata[7:0];
         end
         if (wr && paddr == `RSWC_ADDR_WDT) begin
            watchdog_ctrl_reg <= pwdata[7:0];
         end
         if (wr && paddr == `RSWC_ADDR_WAKE) begin
            wake_enables <= pwdata[7:0];
         end
      end
   end

   // Option, mask and flag registers; a port event beats a clear.
   always @(posedge clk) begin
      if (reset || core_reset) begin
         pin_option_reg_one <= `RSWC_OPT_RST;
         pin_option_reg_two <= `RSWC_OPT_RST;
         pin_option_reg_three <= `RSWC_OPT_RST;
         irq_mask_reg <= 8'h00;
         irq_flags <= 8'h00;
      end else begin
         if (wr && paddr == `RSWC_ADDR_OPT1) begin
            pin_option_reg_one <= pwdata[7:0];
         end
         if (wr && paddr == `RSWC_ADDR_OPT2) begin
            pin_option_reg_two <= pwdata[7:0];
         end
         if (wr && paddr == `RSWC_ADDR_OPT3) begin
            pin_option_reg_three <= pwdata[7:0];
         end
         if (wr && paddr == `RSWC_ADDR_MASK) begin
            irq_mask_reg <= pwdata[7:0];
         end
         if (wr && paddr == `RSWC_ADDR_FLAGS) begin
            irq_flags <= pwdata[7:0];
         end
         if (port_change && irq_mask_reg[`RSWC_MASK_PORT_BIT]) begin
            irq_flags[`RSWC_MASK_PORT_BIT] <= 1'b1;
         end
      end
   end

endmodule // rswc_ctrl

/* File: verilog/rswc_map.vh */
// Constants for the reset, sleep and wake-up controller.
// Assumes a 40 MHz core clock; times are given in microseconds.
`ifndef RSWC_MAP_VH
`define RSWC_MAP_VH

// Clock period in ns, used to turn times into cycle counts.
`define RSWC_CLK_NS 25

// Hold times in microseconds.
`define RSWC_HOLD_US 18000
`define RSWC_SLOW_HOLD_US 500000
`define RSWC_WDT_LONG_US 18000
`define RSWC_WDT_SHORT_US 4500
`define RSWC_XTAL_START_US 2000

// Cycle counts derived from the times above; each division comes out exact.
`define RSWC_HOLD_CYC (`RSWC_HOLD_US * 1000 / `RSWC_CLK_NS)
`define RSWC_SLOW_HOLD_CYC (`RSWC_SLOW_HOLD_US * 1000 / `RSWC_CLK_NS)
`define RSWC_WDT_LONG_CYC (`RSWC_WDT_LONG_US * 1000 / `RSWC_CLK_NS)
`define RSWC_WDT_SHORT_CYC (`RSWC_WDT_SHORT_US * 1000 / `RSWC_CLK_NS)
`define RSWC_XTAL_START_CYC (`RSWC_XTAL_START_US * 1000 / `RSWC_CLK_NS)

// Oscillator-stable clocks and ADC clock periods before resuming.
`define RSWC_OSC_STABLE_CLKS 32
`define RSWC_ADC_RESUME_TAD 15

// Oscillator mode codes.
`define RSWC_OSC_RC 2'h0
`define RSWC_OSC_HXT 2'h1
`define RSWC_OSC_SLOW 2'h2

// Resume vectors.
`define RSWC_VEC_RESET 10'h000
`define RSWC_VEC_PORT 10'h006
`define RSWC_VEC_ADC 10'h00c
`define RSWC_VEC_CMP 10'h00f

// Field positions.
`define RSWC_WAKE_PORT_BIT 1
`define RSWC_WAKE_CMP_BIT 2
`define RSWC_WAKE_ADC_BIT 3
`define RSWC_MASK_PORT_BIT 1
`define RSWC_WDT_EN_BIT 7
`define RSWC_WDT_SHORT_BIT 6
`define RSWC_STAT_TO_BIT 4
`define RSWC_STAT_PD_BIT 3

// APB register byte addresses.
`define RSWC_ADDR_CTRL 12'h000
`define RSWC_ADDR_WDT 12'h004
`define RSWC_ADDR_WAKE 12'h008
`define RSWC_ADDR_MASK 12'h00c
`define RSWC_ADDR_FLAGS 12'h010
`define RSWC_ADDR_STATUS 12'h014
`define RSWC_ADDR_OPT1 12'h018
`define RSWC_ADDR_OPT2 12'h01c
`define RSWC_ADDR_OPT3 12'h020
`define RSWC_ADDR_STATE 12'h024
`define RSWC_ADDR_PORT5 12'h028

// Reset values.
`define RSWC_OPT_RST 8'hff
`define RSWC_WDT_CLR_MASK 8'h4f
`define RSWC_WAKE_CLR_MASK 8'hcf
`define RSWC_STAT_POR_MASK 8'h1f

`endif

/* File: tb/rswc_ctrl_monitor.sv */
// Port checker for the reset, sleep and wake-up controller.
// Assumes it is bound to rswc_ctrl and shares its hold count.
`timescale 1ns/1ps
module rswc_ctrl_monitor #(
   parameter HOLD_CYC = 20
) (
   // Clock and reset.
   input wire clk,
   input wire reset,
   // Bus, pins and strobes.
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire reset_pin_n,
   input wire sleep_instr,
   input wire adc_busy,
   // Core control.
   input wire core_reset,
   input wire osc_run,
   input wire timers_run,
   input wire pc_load,
   input wire [9:0] pc_word,
   input wire port_inputs_only,
   input wire watchdog_timeout
);
   reg [15:0] held_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Length of the current hold; a short hold would release the core early.
   always @(posedge clk) begin
      if (reset || !core_reset) begin
         held_reg <= 16'h0000;
      end else begin
         held_reg <= held_reg + 16'h0001;
      end
   end
   pin_reset_a: assert property (!reset_pin_n |-> ##[0:2] core_reset)
      else $error("pin low without core reset");
   dog_reset_a: assert property (watchdog_timeout |-> ##[0:2] core_reset)
      else $error("watchdog timeout without core reset");
   hold_time_a: assert property ($fell(core_reset) |-> held_reg >= HOLD_CYC - 1)
      else $error("core reset released too early");
   reset_vector_a: assert property (pc_load && ($past(core_reset) ||
      $past(core_reset, 2)) |-> pc_word == 10'h000)
      else $error("reset exit not at address zero");
   load_pulse_a: assert property (pc_load |=> !pc_load)
      else $error("vector load longer than one cycle");
   osc_in_reset_a: assert property (core_reset |-> osc_run)
      else $error("oscillator stopped in reset");
   pins_input_a: assert property (core_reset |-> port_inputs_only)
      else $error("port pins not inputs in reset");
   sleep_stop_a: assert property (sleep_instr && !core_reset && !adc_busy
      |-> ##[1:3] (!osc_run && !timers_run))
      else $error("sleep did not stop the clocks");
   timers_pair_a: assert property (!osc_run |-> !timers_run)
      else $error("timers run with oscillator stopped");
   wake_vector_a: assert property (pc_load |->
      pc_word inside {10'h000, 10'h006, 10'h00c, 10'h00f})
      else $error("vector load with unknown address");
endmodule // rswc_ctrl_monitor
bind rswc_ctrl rswc_ctrl_monitor #(.HOLD_CYC(HOLD_CYC)) i_rswc_ctrl_monitor (
   .clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
   .sleep_instr(sleep_instr), .adc_busy(adc_busy), .core_reset(core_reset),
   .osc_run(osc_run), .timers_run(timers_run), .pc_load(pc_load),
   .pc_word(pc_word), .port_inputs_only(port_inputs_only),
   .watchdog_timeout(watchdog_timeout));

/* File: tb/rswc_core_model.sv */
// Stand-in for core software and the pins around the controller.
// Assumes the bench calls its tasks; every change follows a rising edge.
`timescale 1ns/1ps
module rswc_core_model (
   // Clock.
   input wire clk,
   // Pins.
   output logic reset_pin_n,
   output logic [7:0] port_five_pins,
   // Core strobes.
   output wire sleep_instr,
   output wire clear_watchdog_instr,
   output wire port_five_read,
   output wire comparator_change,
   output wire adc_done,
   output wire adc_clock_tick,
   // Core levels.
   output logic global_irq_on,
   output logic adc_busy,
   output logic [1:0] osc_mode
);
   logic [4:0] strobe = 5'h00;
   logic [1:0] tick_reg = 2'h0;
   // Strobes: sleep, watchdog clear, port read, comparator, ADC done.
   assign sleep_instr = strobe[0];
   assign clear_watchdog_instr = strobe[1];
   assign port_five_read = strobe[2];
   assign comparator_change = strobe[3];
   assign adc_done = strobe[4];
   // The ADC clock ticks once in four core clocks, so ADC wake waits are long.
   assign adc_clock_tick = (tick_reg == 2'h3);
   initial begin
      reset_pin_n = 1'b1;
      port_five_pins = 8'h00;
      global_irq_on = 1'b0;
      adc_busy = 1'b0;
      osc_mode = 2'h0;
   end
   always @(posedge clk) begin
      tick_reg <= tick_reg + 2'h1;
   end
   // One-cycle core strobe.
   task pulse(input int k);
      begin
         @(posedge clk);
         strobe[k] <= 1'b1;
         @(posedge clk);
         strobe <= 5'h00;
      end
   endtask
   // Core levels and the port pins change together after an edge.
   task set(input logic irq, input logic busy, input logic [1:0] m,
            input logic [7:0] p);
      begin
         @(posedge clk);
         global_irq_on <= irq;
         adc_busy <= busy;
         osc_mode <= m;
         port_five_pins <= p;
      end
   endtask
   // The reset pin is held low for three cycles.
   task pin_reset;
      begin
         @(posedge clk);
         reset_pin_n <= 1'b0;
         repeat (3) @(posedge clk);
         reset_pin_n <= 1'b1;
      end
   endtask
endmodule // rswc_core_model

/* File: tb/rswc_ctrl_tb.sv */
// Self-checking bench for the reset, sleep and wake-up controller.
// Assumes shortened hold and watchdog counts so the run stays brief.
`timescale 1ns/1ps
module rswc_ctrl_tb;
   localparam int HOLD = 20;
   localparam int SLOW = 40;
   localparam int WL = 60;
   localparam int WS = 30;
   localparam int XS = 10;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] q;
   logic [9:0] v;
   logic [7:0] pv = 8'h00;
   int n_fail = 0;
   int tests_run = 0;
   int loads = 0;
   int n;
   int l0;
   int waits[3] = '{32, XS + 32, SLOW};
   wire [31:0] prdata;
   wire pready, pslverr, reset_pin_n, sleep_instr, clear_watchdog_instr;
   wire port_five_read, global_irq_on, comparator_change, adc_busy;
   wire adc_done, adc_clock_tick, core_reset, osc_run, timers_run;
   wire adc_stop, pc_load, port_inputs_only, watchdog_timeout;
   wire [7:0] port_five_pins;
   wire [1:0] osc_mode;
   wire [9:0] pc_word;
   rswc_ctrl #(.HOLD_CYC(HOLD), .SLOW_HOLD_CYC(SLOW), .WDT_LONG_CYC(WL),
      .WDT_SHORT_CYC(WS), .XTAL_START_CYC(XS)) i_rswc_ctrl (.clk, .reset,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .reset_pin_n, .port_five_pins, .sleep_instr, .clear_watchdog_instr,
      .port_five_read, .global_irq_on, .comparator_change, .adc_busy,
      .adc_done, .adc_clock_tick, .osc_mode, .core_reset, .osc_run,
      .timers_run, .adc_stop, .pc_load, .pc_word, .port_inputs_only,
      .watchdog_timeout);
   rswc_core_model i_rswc_core_model (.clk, .reset_pin_n, .port_five_pins,
      .sleep_instr, .clear_watchdog_instr, .port_five_read, .comparator_change,
      .adc_done, .adc_clock_tick, .global_irq_on, .adc_busy, .osc_mode);
   // Clock at 40 MHz.
   always #12.5 clk = ~clk;
   // Vector loads are counted to prove a wake that must not branch.
   always @(posedge clk) begin
      if (pc_load === 1'b1) loads <= loads + 1;
   end
   // One APB transfer; the request holds until pready is seen high.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1) @(posedge clk);
         q = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         tests_run++;
         if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task chk_span(input string nm, input int g, input int lo, input int hi);
      begin
         tests_run++;
         if (g < lo || g > hi) begin
            n_fail++;
            $display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, g);
         end
      end
   endtask
   // Masked register read compared with its expected value.
   task chkr(input string nm, input logic [11:0] a, input logic [31:0] m,
             input logic [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, e, q & m);
      end
   endtask
   // Waits for a vector load (sel 0) or a watchdog time-out (sel 1).
   task wait_for(input bit sel);
      begin
         n = 0;
         v = 10'h3ff;
         while (n < 3000 && (sel ? watchdog_timeout : pc_load) !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
         end
         v = pc_word;
         @(posedge clk);
      end
   endtask
   // Values every reset must leave behind.
   task defaults;
      begin
         for (int i = 0; i < 3; i++) chkr("opt", 12'h018 + 4 * i, 32'hff, 32'hff);
         chkr("wdt", 12'h004, 32'hb0, 32'h0);
         chkr("wake", 12'h008, 32'h30, 32'h0);
         chkr("mask", 12'h00c, 32'hff, 32'h0);
         chkr("flags", 12'h010, 32'hff, 32'h0);
      end
   endtask
   // Sleep entry: port read, interrupt state, wake enable, then sleep.
   task go_sleep(input logic irq, input logic busy, input logic [1:0] m,
                 input logic [7:0] wk);
      begin
         i_rswc_core_model.pulse(2);
         i_rswc_core_model.set(irq, busy, m, pv);
         apb(1'b1, 12'h008, {24'h0, wk});
         i_rswc_core_model.pulse(0);
         repeat (4) @(posedge clk);
      end
   endtask
   task test_done;
      begin
         $display("checks %0d failures %0d", tests_run, n_fail);
         if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   // Hang guard, far beyond the under a thousand cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      wait_for(0);
      chk_span("por_hold", n, HOLD - 1, HOLD + 8);
      chk("por_vector", 32'h0, v);
      defaults;
      chkr("status_top", 12'h014, 32'he0, 32'h0);
      chkr("unmapped", 12'hffc, 32'hffffffff, 32'h0);
      $display("test power_on done");
      apb(1'b1, 12'h004, 32'h30);
      apb(1'b1, 12'h008, 32'h30);
      for (int i = 0; i < 3; i++) apb(1'b1, 12'h018 + 4 * i, 32'h0);
      apb(1'b1, 12'h00c, 32'h02);
      i_rswc_core_model.pin_reset;
      wait_for(0);
      chk("pin_vector", 32'h0, v);
      defaults;
      i_rswc_core_model.set(1'b0, 1'b0, 2'h2, pv);
      i_rswc_core_model.pin_reset;
      wait_for(0);
      chk_span("slow_hold", n, SLOW - 3, SLOW + 8);
      $display("test pin_reset done");
      apb(1'b1, 12'h00c, 32'h02);
      for (int m = 0; m < 3; m++) begin
         go_sleep(1'b1, 1'b0, m[1:0], 8'h02);
         pv = pv ^ (8'h01 << m);
         i_rswc_core_model.set(1'b1, 1'b0, m[1:0], pv);
         wait_for(0);
         chk("port_vector", 32'h006, v);
         chk_span("port_wait", n, waits[m], waits[m] + 8);
      end
      go_sleep(1'b0, 1'b0, 2'h0, 8'h02);
      l0 = loads;
      pv = pv ^ 8'h80;
      i_rswc_core_model.set(1'b0, 1'b0, 2'h0, pv);
      repeat (60) @(posedge clk);
      chk("no_vector", l0, loads);
      chk("resumed", 1'b1, osc_run);
      go_sleep(1'b1, 1'b0, 2'h0, 8'h04);
      i_rswc_core_model.pulse(3);
      wait_for(0);
      chk("cmp_vector", 32'h00f, v);
      chk_span("cmp_wait", n, 31, 40);
      $display("test pin_change done");
      go_sleep(1'b1, 1'b1, 2'h0, 8'h08);
      chk("adc_osc", 1'b1, osc_run && timers_run);
      i_rswc_core_model.set(1'b1, 1'b0, 2'h0, pv);
      i_rswc_core_model.pulse(4);
      wait_for(0);
      chk("adc_vector", 32'h00c, v);
      chk_span("adc_wait", n, 56, 68);
      go_sleep(1'b1, 1'b1, 2'h0, 8'h00);
      chk("adc_halt", 1'b1, adc_stop);
      chk("osc_halt", 1'b0, osc_run);
      i_rswc_core_model.pin_reset;
      wait_for(0);
      chk("wake_vector", 32'h0, v);
      chk("osc_back", 1'b1, osc_run);
      $display("test adc_wake done");
      i_rswc_core_model.set(1'b0, 1'b0, 2'h0, pv);
      apb(1'b1, 12'h004, 32'hc0);
      wait_for(1);
      chk_span("wdt_short", n, WS - 2, WS + 4);
      wait_for(0);
      chk("wdt_vector", 32'h0, v);
      apb(1'b1, 12'h004, 32'h80);
      repeat (WL / 2) @(posedge clk);
      i_rswc_core_model.pulse(1);
      wait_for(1);
      chk_span("wdt_long", n, WL - 4, WL + 4);
      wait_for(0);
      $display("test watchdog done");
      test_done;
   end
endmodule // rswc_ctrl_tb
